// ### common/axirc_pkg.sv
// Constants shared by the axis input response block.
package axirc_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFF_ENV1 = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [31:0] ENV1_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // Field positions in axis_environment_setting_one.
  localparam int LIMIT_STOP_MODE_SEL    = 3;
  localparam int SLOWDOWN_ACTION_SEL    = 4;
  localparam int SLOWDOWN_LATCH_EN      = 5;
  localparam int SLOWDOWN_POLARITY      = 6;
  localparam int ORIGIN_POLARITY        = 7;
  localparam int ALARM_STOP_MODE_SEL    = 8;
  localparam int ALARM_POLARITY         = 9;
  localparam int CLEAR_ON_EMERG_STOP_EN = 10;
  localparam int CLEAR_ON_HOME_DONE_EN  = 11;
  localparam int CLEAR_PULSE_WIDTH_LSB  = 12;
  localparam int CLEAR_PULSE_WIDTH_MSB  = 14;

  // Status bit positions; the mask register has the same layout.
  localparam int ST_LIMIT_IMM   = 0;
  localparam int ST_LIMIT_DEC   = 1;
  localparam int ST_SLOWDOWN    = 2;
  localparam int ST_ALARM       = 3;
  localparam int ST_EMERGENCY   = 4;
  localparam int ST_HOME_CLEAR  = 5;
  localparam int ST_LIMIT_NORM  = 6;
  localparam int ST_W           = 7;

  // Synchroniser lanes for the sensor pins.
  localparam int PIN_LIMIT_POS = 0;
  localparam int PIN_LIMIT_NEG = 1;
  localparam int PIN_SLOWDOWN  = 2;
  localparam int PIN_ORIGIN    = 3;
  localparam int PIN_ALARM     = 4;
  localparam int PIN_EMERG     = 5;
  localparam int PIN_W         = 6;

  // Feed-to-end-limit operation mode pattern 010X000.
  localparam logic [6:0] FEED_LIMIT_MASK = 7'h77;
  localparam logic [6:0] FEED_LIMIT_CODE = 7'h20;

  // Clear pulse widths and their cycle counts at the reference clock.
  localparam int CLK_MHZ      = 100;
  localparam int PW0_NS       = 12000;
  localparam int PW1_NS       = 102000;
  localparam int PW2_NS       = 409000;
  localparam int PW3_NS       = 1600000;
  localparam int PW0_CYC      = PW0_NS * CLK_MHZ / 1000;
  localparam int PW1_CYC      = PW1_NS * CLK_MHZ / 1000;
  localparam int PW2_CYC      = PW2_NS * CLK_MHZ / 1000;
  localparam int PW3_CYC      = PW3_NS * CLK_MHZ / 1000;
  localparam int PW_CNT_W     = 18;
endpackage

// ### design/axirc_pulse.sv
// Deviation-clear pulse timer with selectable width.
`timescale 1ns/1ns
module axirc_pulse #(
  parameter int PW0 = axirc_pkg::PW0_CYC,
  parameter int PW1 = axirc_pkg::PW1_CYC,
  parameter int PW2 = axirc_pkg::PW2_CYC,
  parameter int PW3 = axirc_pkg::PW3_CYC
) (
  input  wire logic       mclk,     // Reference clock.
  input  wire logic       rst_b,    // Asynchronous reset, active low.
  input  wire logic       trig,     // One-cycle start of a pulse.
  input  wire logic [2:0] widthSel, // Pulse width code.
  output logic            pulse_r   // Clear pulse, active high.
);
  localparam int CW = axirc_pkg::PW_CNT_W;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] load;

  // Codes above 011 reuse the longest width.
  always_comb begin
    unique case (widthSel)
      3'h0:    load = CW'(PW0 - 1);
      3'h1:    load = CW'(PW1 - 1);
      3'h2:    load = CW'(PW2 - 1);
      default: load = CW'(PW3 - 1);
    endcase
  end

  // A new trigger during a pulse restarts the full width.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= '0;
      pulse_r <= 1'b0;
    end else if (trig) begin
      cnt_r   <= load;
      pulse_r <= 1'b1;
    end else if (pulse_r) begin
      cnt_r   <= cnt_r - CW'(1);
      pulse_r <= (cnt_r != '0);
    end
  end
endmodule // axirc_pulse

// ### design/axirc_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ns
module axirc_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             mclk,   // Reference clock.
  input  wire logic             rst_b,  // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] pinIn,  // Raw pin levels.
  output logic      [WIDTH-1:0] pinOut  // Filtered levels.
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  wire  [WIDTH-1:0] agree = ~(s2_r ^ s3_r);

  // Pins idle high, since the sensor lines are pulled up.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r   <= '1;
      s2_r   <= '1;
      s3_r   <= '1;
      pinOut <= '1;
    end else begin
      s1_r   <= pinIn;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      pinOut <= (agree & s2_r) | (~agree & pinOut);
    end
  end
endmodule // axirc_sync

// ### design/axirc_top.sv
// Axis sensor response, slow-down latch and deviation-clear control.
`timescale 1ns/1ns
module axirc_top #(
  parameter int PW0 = axirc_pkg::PW0_CYC,
  parameter int PW1 = axirc_pkg::PW1_CYC,
  parameter int PW2 = axirc_pkg::PW2_CYC,
  parameter int PW3 = axirc_pkg::PW3_CYC
) (
  input  wire logic        mclk,          // Reference clock, 100 MHz.
  input  wire logic        rst_b,         // Asynchronous reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB access phase.
  input  wire logic        pwrite,        // APB write.
  input  wire logic [7:0]  paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata_r,      // APB read data.
  output logic             pready_r,      // APB ready.
  output logic             pslverr_r,     // APB error, unmapped address.
  input  wire logic        limitPos_b,    // Plus end limit pin, low active.
  input  wire logic        limitNeg_b,    // Minus end limit pin, low active.
  input  wire logic        slowdownIn,    // Slow-down pin.
  input  wire logic        originIn,      // Origin pin.
  input  wire logic        alarmIn,       // Alarm pin.
  input  wire logic        emergency_b,   // Common emergency pin, low active.
  input  wire logic        axisMoving,    // Axis is outputting pulses.
  input  wire logic        motionStart,   // One-cycle motion start.
  input  wire logic        homeDone,      // One-cycle zero return done.
  input  wire logic [6:0]  opMode,        // Operation mode field.
  output logic             immStop_r,     // One-cycle immediate stop.
  output logic             decelStop_r,   // One-cycle decelerating stop.
  output logic             slowDecel_r,   // Slow-down deceleration level.
  output logic             originDet_r,   // Origin sensed, level.
  output logic             devClear,      // Deviation-clear output pulse.
  output logic             irq_r          // Interrupt, level.
);
  logic [31:0]              env_r;
  logic [axirc_pkg::ST_W-1:0] stat_r;
  logic [axirc_pkg::ST_W-1:0] mask_r;
  logic [axirc_pkg::PIN_W-1:0] pins;
  logic                     sdLatch_r;
  logic                     limPosPrev_r;
  logic                     limNegPrev_r;
  logic                     sdEffPrev_r;
  logic                     almPrev_r;
  logic                     emgPrev_r;

  axirc_sync #(
    .WIDTH (axirc_pkg::PIN_W)
  ) u_sync (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .pinIn  ({emergency_b, alarmIn, originIn, slowdownIn,
              limitNeg_b, limitPos_b}),
    .pinOut (pins)
  );

  function automatic logic sense(input logic lvl, input logic pol);
    sense = pol ? lvl : ~lvl;
  endfunction

  // Environment fields.
  wire limMode  = env_r[axirc_pkg::LIMIT_STOP_MODE_SEL];
  wire sdAction = env_r[axirc_pkg::SLOWDOWN_ACTION_SEL];
  wire sdLatEn  = env_r[axirc_pkg::SLOWDOWN_LATCH_EN];
  wire sdPol    = env_r[axirc_pkg::SLOWDOWN_POLARITY];
  wire orgPol   = env_r[axirc_pkg::ORIGIN_POLARITY];
  wire almMode  = env_r[axirc_pkg::ALARM_STOP_MODE_SEL];
  wire almPol   = env_r[axirc_pkg::ALARM_POLARITY];
  wire clrEmg   = env_r[axirc_pkg::CLEAR_ON_EMERG_STOP_EN];
  wire clrHome  = env_r[axirc_pkg::CLEAR_ON_HOME_DONE_EN];
  wire [2:0] pwSel = env_r[axirc_pkg::CLEAR_PULSE_WIDTH_MSB:
                           axirc_pkg::CLEAR_PULSE_WIDTH_LSB];

  // Sensed levels.
  wire limPosAct = ~pins[axirc_pkg::PIN_LIMIT_POS];
  wire limNegAct = ~pins[axirc_pkg::PIN_LIMIT_NEG];
  wire sdAct  = sense(pins[axirc_pkg::PIN_SLOWDOWN], sdPol);
  wire orgAct = sense(pins[axirc_pkg::PIN_ORIGIN], orgPol);
  wire almAct = sense(pins[axirc_pkg::PIN_ALARM], almPol);
  wire emgAct = ~pins[axirc_pkg::PIN_EMERG];

  // The latch is built so that a set in the clearing cycle still wins.
  wire sdLatchClr = ~sdLatEn | (motionStart & ~sdAct);
  wire sdLatchNxt = sdLatEn & (sdAct | (sdLatch_r & ~sdLatchClr));
  wire sdEff      = sdAct | sdLatch_r;

  // Edges; every stop event needs a moving axis.
  wire limEdge = (limPosAct & ~limPosPrev_r) | (limNegAct & ~limNegPrev_r);
  wire sdEdge  = sdEff & ~sdEffPrev_r;
  wire almEdge = almAct & ~almPrev_r;
  wire emgEdge = emgAct & ~emgPrev_r;
  wire limImm  = axisMoving & limEdge & ~limMode;
  wire limDec  = axisMoving & limEdge & limMode;
  wire almImm  = axisMoving & almEdge & ~almMode;
  wire almDec  = axisMoving & almEdge & almMode;
  wire emgImm  = axisMoving & emgEdge;
  wire sdStop  = axisMoving & sdEdge & sdAction;
  wire immNxt  = limImm | almImm | emgImm;
  wire decNxt  = limDec | almDec | sdStop;

  // Feed-to-limit only adds a normal-stop status bit to the limit stop.
  wire feedLimit = (opMode & axirc_pkg::FEED_LIMIT_MASK) ==
                   axirc_pkg::FEED_LIMIT_CODE;
  wire limNorm   = feedLimit & axisMoving & limEdge;

  // Of the stop terms only the immediate ones trigger, never the decelerating ones.
  wire clrTrig = (clrEmg & immNxt) |
                 (clrHome & homeDone);

  axirc_pulse #(
    .PW0 (PW0),
    .PW1 (PW1),
    .PW2 (PW2),
    .PW3 (PW3)
  ) u_pulse (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .trig     (clrTrig),
    .widthSel (pwSel),
    .pulse_r  (devClear)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sdLatch_r    <= 1'b0;
      limPosPrev_r <= 1'b0;
      limNegPrev_r <= 1'b0;
      sdEffPrev_r  <= 1'b0;
      almPrev_r    <= 1'b0;
      emgPrev_r    <= 1'b0;
      immStop_r    <= 1'b0;
      decelStop_r  <= 1'b0;
      slowDecel_r  <= 1'b0;
      originDet_r  <= 1'b0;
    end else begin
      sdLatch_r    <= sdLatchNxt;
      limPosPrev_r <= limPosAct;
      limNegPrev_r <= limNegAct;
      sdEffPrev_r  <= sdEff;
      almPrev_r    <= almAct;
      emgPrev_r    <= emgAct;
      immStop_r    <= immNxt;
      decelStop_r  <= decNxt;
      slowDecel_r  <= axisMoving & sdEff;
      originDet_r  <= orgAct;
    end
  end

  // APB slave: one wait state so that read data leaves a flip-flop.
  wire access  = psel & penable;
  wire capture = access & ~pready_r;
  wire selEnv  = paddr == axirc_pkg::OFF_ENV1;
  wire selStat = paddr == axirc_pkg::OFF_STAT;
  wire selMask = paddr == axirc_pkg::OFF_MASK;
  wire mapped  = selEnv | selStat | selMask;
  wire wrDone  = access & pready_r & pwrite;
  wire statClr = capture & ~pwrite & selStat;

  wire [axirc_pkg::ST_W-1:0] events = {limNorm, clrHome & homeDone,
                                       emgImm, almImm | almDec, sdEdge &
                                       axisMoving, limDec, limImm};
  wire [axirc_pkg::ST_W-1:0] statNxt = events | (stat_r &
                                       ~{axirc_pkg::ST_W{statClr}});
  wire [31:0] rdMux = selEnv  ? env_r :
                      selStat ? 32'(stat_r) :
                      selMask ? 32'(mask_r) : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      env_r     <= axirc_pkg::ENV1_RST;
      mask_r    <= axirc_pkg::MASK_RST[axirc_pkg::ST_W-1:0];
      stat_r    <= '0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      stat_r    <= statNxt;
      irq_r     <= |(statNxt & mask_r);
      pready_r  <= capture;
      pslverr_r <= capture & ~mapped;
      if (capture) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
      end
      if (wrDone && selEnv) begin
        env_r <= pwdata;
      end
      if (wrDone && selMask) begin
        mask_r <= pwdata[axirc_pkg::ST_W-1:0];
      end
    end
  end

  // Checks.
  sequence s_immTrig;
    clrEmg && immNxt;
  endsequence
  // Four cycles is the shortest width expected; the exact width is checked
  // separately at the end of every pulse.
  sequence s_pulseRun;
    devClear [*4];
  endsequence

  property p_limImm;
    @(posedge mclk) disable iff (!rst_b)
      axisMoving && limEdge && !limMode |=> immStop_r && !decelStop_r;
  endproperty
  a_limImm: assert property (p_limImm)
    else $error("limit imm stop");

  property p_limDec;
    @(posedge mclk) disable iff (!rst_b)
      axisMoving && limEdge && limMode && !emgEdge && !almEdge
        |=> decelStop_r && !immStop_r;
  endproperty
  a_limDec: assert property (p_limDec)
    else $error("limit decel stop");

  property p_sdStop;
    @(posedge mclk) disable iff (!rst_b)
      axisMoving && sdEdge |=> slowDecel_r && (decelStop_r == $past(sdAction)
        || $past(limEdge || almEdge));
  endproperty
  a_sdStop: assert property (p_sdStop)
    else $error("slow-down action");

  property p_latchHold;
    @(posedge mclk) disable iff (!rst_b)
      sdLatEn && sdAct |=> sdLatch_r || !$past(sdLatEn);
  endproperty
  a_latchHold: assert property (p_latchHold)
    else $error("latch set");

  property p_latchStart;
    @(posedge mclk) disable iff (!rst_b)
      motionStart && !sdAct |=> !sdLatch_r;
  endproperty
  a_latchStart: assert property (p_latchStart)
    else $error("latch clr");

  property p_latchOff;
    @(posedge mclk) disable iff (!rst_b)
      !sdLatEn |=> !sdLatch_r;
  endproperty
  a_latchOff: assert property (p_latchOff)
    else $error("latch off");

  property p_almImm;
    @(posedge mclk) disable iff (!rst_b)
      axisMoving && almEdge && !almMode |=> immStop_r;
  endproperty
  a_almImm: assert property (p_almImm)
    else $error("alarm imm stop");

  property p_orgPol;
    @(posedge mclk) disable iff (!rst_b)
      1'b1 |=> originDet_r == (pins[axirc_pkg::PIN_ORIGIN] ~^ $past(orgPol))
        || $changed(pins[axirc_pkg::PIN_ORIGIN]);
  endproperty
  a_orgPol: assert property (p_orgPol)
    else $error("origin polarity");

  property p_clrEmg;
    @(posedge mclk) disable iff (!rst_b)
      s_immTrig |=> s_pulseRun;
  endproperty
  a_clrEmg: assert property (p_clrEmg)
    else $error("no clear pulse");

  property p_noClrDec;
    @(posedge mclk) disable iff (!rst_b)
      !devClear && !(clrHome && homeDone) && !immNxt |=> !devClear;
  endproperty
  a_noClrDec: assert property (p_noClrDec)
    else $error("stray clear");

  property p_clrHome;
    @(posedge mclk) disable iff (!rst_b)
      clrHome && homeDone |=> devClear;
  endproperty
  a_clrHome: assert property (p_clrHome)
    else $error("home clear");

  // Run length of the clear pulse, restarted by each trigger. The width code
  // must not change during a pulse, or this check compares the wrong width.
  localparam int CRW = axirc_pkg::PW_CNT_W;
  logic [CRW-1:0] clrRun_r;
  wire  [CRW-1:0] pwExp = pwSel == 3'h0 ? CRW'(PW0) :
                          pwSel == 3'h1 ? CRW'(PW1) :
                          pwSel == 3'h2 ? CRW'(PW2) : CRW'(PW3);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clrRun_r <= '0;
    end else if (clrTrig || !devClear) begin
      clrRun_r <= '0;
    end else begin
      clrRun_r <= clrRun_r + CRW'(1);
    end
  end

  property p_clrWidth;
    @(posedge mclk) disable iff (!rst_b)
      $fell(devClear) |-> clrRun_r == pwExp;
  endproperty
  a_clrWidth: assert property (p_clrWidth)
    else $error("clear width");
endmodule // axirc_top

// ### tb/axirc_drv_model.sv
// Model of the axis sensors and the servo driver that takes the clear pulse.
`timescale 1ns/1ns
module axirc_drv_model (
  input  wire logic        mclk,        // Reference clock.
  input  wire logic        rst_b,       // Reset, active low.
  input  wire logic [5:0]  sensAct,     // Sensor activity, one per lane.
  input  wire logic [31:0] env,         // Environment word as written.
  input  wire logic        devClear,    // Deviation-clear from the axis.
  output logic             limitPos_b,  // Plus end limit pin.
  output logic             limitNeg_b,  // Minus end limit pin.
  output logic             slowdownIn,  // Slow-down pin.
  output logic             originIn,    // Origin pin.
  output logic             alarmIn,     // Alarm pin.
  output logic             emergency_b, // Common emergency pin.
  output logic [7:0]       clrCnt,      // Clear pulses seen.
  output logic [7:0]       clrLen       // Width of the last clear pulse.
);
  logic [7:0] runLen;
  // An idle sensor sits at its inactive level for the chosen logic.
  assign limitPos_b  = ~sensAct[0];
  assign limitNeg_b  = ~sensAct[1];
  assign slowdownIn  = sensAct[2] ~^ env[6];
  assign originIn    = sensAct[3] ~^ env[7];
  assign alarmIn     = sensAct[4] ~^ env[9];
  assign emergency_b = ~sensAct[5];
  // The driver counts a pulse when it ends, so its width is known then.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      runLen <= 8'h00;
      clrCnt <= 8'h00;
      clrLen <= 8'h00;
    end else if (devClear) begin
      runLen <= runLen + 8'h01;
    end else if (runLen != 8'h00) begin
      clrCnt <= clrCnt + 8'h01;
      clrLen <= runLen;
      runLen <= 8'h00;
    end
  end
endmodule // axirc_drv_model

// ### tb/axis_input_response_config_tb_top.sv
// Self-checking bench for the axis input response block.
`timescale 1ns/1ns
module axis_input_response_config_tb_top;
  localparam int PW [4] = '{4, 6, 8, 10};
  logic        mclk, rst_b, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_r, env, rd;
  logic        pready_r, pslverr_r, axisMoving, motionStart, homeDone;
  logic [6:0]  opMode;
  logic [5:0]  sensAct;
  logic        limitPos_b, limitNeg_b, slowdownIn, originIn, alarmIn;
  logic        emergency_b, immStop_r, decelStop_r, slowDecel_r;
  logic        originDet_r, devClear, irq_r, er;
  logic [7:0]  clrCnt, clrLen;
  int          errCount, testsRun;

  axirc_top #(.PW0(PW[0]), .PW1(PW[1]), .PW2(PW[2]), .PW3(PW[3])) DUT (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .limitPos_b(limitPos_b),
    .limitNeg_b(limitNeg_b), .slowdownIn(slowdownIn), .originIn(originIn),
    .alarmIn(alarmIn), .emergency_b(emergency_b), .axisMoving(axisMoving),
    .motionStart(motionStart), .homeDone(homeDone), .opMode(opMode),
    .immStop_r(immStop_r), .decelStop_r(decelStop_r),
    .slowDecel_r(slowDecel_r), .originDet_r(originDet_r),
    .devClear(devClear), .irq_r(irq_r));

  axirc_drv_model u_drv (
    .mclk(mclk), .rst_b(rst_b), .sensAct(sensAct), .env(env),
    .devClear(devClear), .limitPos_b(limitPos_b), .limitNeg_b(limitNeg_b),
    .slowdownIn(slowdownIn), .originIn(originIn), .alarmIn(alarmIn),
    .emergency_b(emergency_b), .clrCnt(clrCnt), .clrLen(clrLen));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready_r !== 1'b1 && n < 20);
    rd = prdata_r;
    er = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n >= 20), 32'h0);
  endtask

  // Settings change with the axis idle, so a polarity swap is no event.
  task automatic cfg(input logic [31:0] v);
    axisMoving <= 1'b0;
    apb(1'b1, axirc_pkg::OFF_ENV1, v);
    env <= v;
    repeat (8) @(posedge mclk);
    axisMoving <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  task automatic hold(input int ln, input logic v, input int n);
    sensAct[ln] <= v;
    repeat (n) @(posedge mclk);
  endtask

  task automatic fire(input int ln, input int eI, input int eD, input int eC);
    int nI = 0;
    int nD = 0;
    int c0 = clrCnt;
    sensAct[ln] <= 1'b1;
    repeat (16) begin
      @(posedge mclk);
      nI += int'(immStop_r === 1'b1);
      nD += int'(decelStop_r === 1'b1);
    end
    hold(ln, 1'b0, 8);
    chk(nI, eI);
    chk(nD, eD);
    chk(clrCnt - c0, eC);
  endtask

  task automatic home(input logic [31:0] v, input int n, input int w);
    int c0;
    cfg(v);
    c0 = clrCnt;
    homeDone <= 1'b1;
    @(posedge mclk);
    homeDone <= 1'b0;
    repeat (14) @(posedge mclk);
    chk(clrCnt - c0, n);
    if (n > 0) begin
      chk(clrLen, w);
    end
  endtask

  task automatic t_regs;
    apb(1'b0, axirc_pkg::OFF_ENV1, 32'h0);
    chk(rd, axirc_pkg::ENV1_RST);
    apb(1'b0, axirc_pkg::OFF_MASK, 32'h0);
    chk(rd, axirc_pkg::MASK_RST);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    chk(er, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, axirc_pkg::OFF_ENV1, 32'h5A5A_A5A5);
    apb(1'b0, axirc_pkg::OFF_ENV1, 32'h0);
    chk(rd, 32'h5A5A_A5A5);
    $display("test registers done");
  endtask

  task automatic t_limit;
    apb(1'b1, axirc_pkg::OFF_MASK, 32'h1);
    cfg(32'h400);
    fire(axirc_pkg::PIN_LIMIT_POS, 1, 0, 1);
    chk(clrLen, PW[0]);
    chk(irq_r, 1'b1);
    apb(1'b0, axirc_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, axirc_pkg::OFF_STAT, 32'h0);
    chk(irq_r, 1'b0);
    chk(rd, 32'h0);
    cfg(32'h408);
    fire(axirc_pkg::PIN_LIMIT_NEG, 0, 1, 0);
    chk(irq_r, 1'b0);
    apb(1'b0, axirc_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h2);
    $display("test limit done");
  endtask

  task automatic t_alarm;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 2; m++) begin
        cfg(32'h400 | (p << 9) | (m << 8));
        fire(axirc_pkg::PIN_ALARM, 1 - m, m, 1 - m);
      end
    end
    fire(axirc_pkg::PIN_EMERG, 1, 0, 1);
    $display("test alarm done");
  endtask

  task automatic t_slow;
    for (int p = 0; p < 2; p++) begin
      cfg(p << 6);
      hold(2, 1'b1, 8);
      chk(slowDecel_r, 1'b1);
      hold(2, 1'b0, 8);
      chk(slowDecel_r, 1'b0);
      cfg((p << 6) | 32'h10);
      fire(axirc_pkg::PIN_SLOWDOWN, 0, 1, 0);
    end
    // Swap the polarity back with the latch off first; a swap with the
    // latch on would set it from the pin's stale level.
    cfg(32'h00);
    cfg(32'h20);
    chk(slowDecel_r, 1'b0);
    hold(2, 1'b1, 4);
    hold(2, 1'b0, 10);
    chk(slowDecel_r, 1'b1);
    motionStart <= 1'b1;
    @(posedge mclk);
    motionStart <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(slowDecel_r, 1'b0);
    hold(2, 1'b1, 4);
    hold(2, 1'b0, 10);
    apb(1'b1, axirc_pkg::OFF_ENV1, 32'h0);
    repeat (3) @(posedge mclk);
    chk(slowDecel_r, 1'b0);
    hold(2, 1'b1, 4);
    hold(2, 1'b0, 10);
    chk(slowDecel_r, 1'b0);
    $display("test slow-down done");
  endtask

  task automatic t_misc;
    for (int p = 0; p < 2; p++) begin
      cfg(p << 7);
      hold(3, 1'b1, 8);
      chk(originDet_r, 1'b1);
      hold(3, 1'b0, 8);
      chk(originDet_r, 1'b0);
    end
    for (int c = 0; c < 4; c++) begin
      home(32'h800 | (c << 12), 1, PW[c]);
    end
    home(32'h0, 0, 0);
    apb(1'b1, axirc_pkg::OFF_MASK, 32'h40);
    opMode <= 7'h28;
    cfg(32'h400);
    fire(axirc_pkg::PIN_LIMIT_POS, 1, 0, 1);
    chk(irq_r, 1'b1);
    apb(1'b0, axirc_pkg::OFF_STAT, 32'h0);
    chk(rd[6], 1'b1);
    opMode <= 7'h00;
    $display("test origin, home and feed done");
  endtask

  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, axisMoving, motionStart, homeDone} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    env = 32'h0;
    opMode = 7'h00;
    sensAct = 6'h00;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs;
    t_limit;
    t_alarm;
    t_slow;
    t_misc;
    test_done;
  end

  // The whole sequence needs under 3000 cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge mclk);
    chk(32'h0, 32'h1);
    test_done;
  end
endmodule // axis_input_response_config_tb_top
